// file: logic/mii_port.v
// mii port to an external pmd, with pins shared with the boot rom address
`timescale 1ns/1ns
`include "mii_port_defines.vh"
module mii_port (
  input wire MCLK,
  input wire RESET_N,
  input wire EXTERNAL_PHY_SELECT,
  input wire ROM_ACCESS,
  input wire [`MII_ROM_ADDR_MSB:`MII_ROM_RXD_LSB] BOOT_ROM_ADDRESS,
  input wire [`MII_NIBBLE_WIDTH-1:0] TX_DATA,
  input wire TX_VALID,
  output wire TX_READY,
  output reg [`MII_NIBBLE_WIDTH-1:0] RX_DATA,
  output reg RX_DATA_VALID,
  output reg RX_ERROR,
  output reg RX_STROBE,
  output reg CARRIER_SENSE,
  output reg COLLISION,
  input wire MGMT_REQ,
  input wire MGMT_DRIVE,
  input wire MGMT_BIT,
  output wire MGMT_READY,
  output reg MGMT_DONE,
  output reg MGMT_SAMPLE,
  input wire COL,
  input wire CRS,
  input wire TXCLK,
  input wire RXCLK,
  input wire [`MII_NIBBLE_WIDTH-1:0] RXD_IN,
  output reg [`MII_NIBBLE_WIDTH-1:0] RXD_OUT,
  output reg RXD_OE,
  input wire RXDV_IN,
  output reg RXDV_OUT,
  output reg RXDV_OE,
  input wire RXER_IN,
  output reg RXER_OUT,
  output reg RXER_OE,
  output reg PMD_RECEIVE_OUTPUT_ENABLE,
  output reg PMD_RECEIVE_OUTPUT_ENABLE_OE,
  output reg [`MII_NIBBLE_WIDTH-1:0] TXD,
  output reg TXD_OE,
  output reg TXEN,
  output reg TXEN_OE,
  output reg MDC,
  output reg MDC_OE,
  input wire MDIO_IN,
  output reg MDIO_OUT,
  output reg MDIO_OE
);
  // half period of mdc in mclk cycles, rounded up so mdc never runs fast
  localparam integer MDC_HALF =
    (`MII_MCLK_FREQ_KHZ + 2 * `MII_MDC_MAX_FREQ_KHZ - 1) / (2 * `MII_MDC_MAX_FREQ_KHZ);
  localparam integer SAMPLE_AT_FULL = MDC_HALF - 1; // full width, cut to the counter below
  localparam integer LAST_FULL = 2 * MDC_HALF - 1; // full width, cut to the counter below
  localparam [7:0] MDC_SAMPLE_AT = SAMPLE_AT_FULL[7:0]; // last count before the rising edge
  localparam [7:0] MDC_LAST = LAST_FULL[7:0]; // last count before the falling edge
  localparam SYNC_WIDTH = 11; // col, crs, txclk, rxclk, rxd x4, rxdv, rxer, mdio

  // synchronised copies of every asynchronous pin
  wire [SYNC_WIDTH-1:0] sync_bus;
  wire col_s; // synchronised collision
  wire crs_s; // synchronised carrier sense
  wire txclk_s; // sampled transmit clock level
  wire rxclk_s; // sampled receive clock level
  wire [`MII_NIBBLE_WIDTH-1:0] rxd_s; // sampled receive nibble
  wire rxdv_s; // sampled receive valid
  wire rxer_s; // sampled receive error
  wire mdio_s; // sampled management data

  // clock levels one cycle older, for edge finding
  reg txclk_d;
  reg rxclk_d;
  wire tx_fall; // transmit clock fell: time to change txd and txen
  wire rx_rise; // receive clock rose: receive pins are settled
  reg [1:0] warm; // edges since reset; the delayed levels need three for true history
  wire links_ready; // edge finding trusted only once warm is full, so no false edge

  // management clock phase and bit bookkeeping
  reg [7:0] mdc_count;
  reg bit_active; // a requested bit occupies the current mdc period
  wire mdc_wrap;

  // rom access gated by the external phy select
  wire rom_on;

  // carrier, collision and every link pin pass the two-stage bank
  mii_input_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .ASYNC_IN({COL, CRS, TXCLK, RXCLK, RXD_IN, RXDV_IN, RXER_IN, MDIO_IN}),
    .SYNC_OUT(sync_bus)
  );

  assign col_s = sync_bus[10];
  assign crs_s = sync_bus[9];
  assign txclk_s = sync_bus[8];
  assign rxclk_s = sync_bus[7];
  assign rxd_s = sync_bus[6:3];
  assign rxdv_s = sync_bus[2];
  assign rxer_s = sync_bus[1];
  assign mdio_s = sync_bus[0];

  // edges found from synchronised levels only; sampling a 25 mhz link
  // clock with a 20 mhz mclk cannot work, so only 10 mb/s is carried
  assign links_ready = (warm == 2'h3);
  assign tx_fall = txclk_d & ~txclk_s & links_ready;
  assign rx_rise = rxclk_s & ~rxclk_d & links_ready;
  assign rom_on = ROM_ACCESS & EXTERNAL_PHY_SELECT;
  assign mdc_wrap = (mdc_count == MDC_LAST);

  // transmit accepts a nibble only at a transmit clock fall, outside rom use
  assign TX_READY = tx_fall & EXTERNAL_PHY_SELECT & ~ROM_ACCESS;
  // a management bit is taken just before mdc falls
  assign MGMT_READY = mdc_wrap & EXTERNAL_PHY_SELECT;

  // delayed clock levels
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      txclk_d <= 1'b0;
      rxclk_d <= 1'b0;
      warm <= 2'h0;
    end else begin
      txclk_d <= txclk_s;
      rxclk_d <= rxclk_s;
      // count up to three after reset, then hold
      if (!links_ready) begin
        warm <= warm + 2'h1;
      end
    end
  end

  // output enables: nothing driven unless the external phy is selected
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TXD_OE <= 1'b0;
      TXEN_OE <= 1'b0;
      MDC_OE <= 1'b0;
      PMD_RECEIVE_OUTPUT_ENABLE_OE <= 1'b0;
      RXD_OE <= 1'b0;
      RXDV_OE <= 1'b0;
      RXER_OE <= 1'b0;
    end else begin
      TXD_OE <= EXTERNAL_PHY_SELECT;
      TXEN_OE <= EXTERNAL_PHY_SELECT;
      MDC_OE <= EXTERNAL_PHY_SELECT;
      PMD_RECEIVE_OUTPUT_ENABLE_OE <= EXTERNAL_PHY_SELECT;
      // receive pins turn to outputs only while the rom is addressed
      RXD_OE <= rom_on;
      RXDV_OE <= rom_on;
      RXER_OE <= rom_on;
    end
  end

  // pmd silenced for each rom access; the rx pins turn round in the same
  // edge, so a board needs the pmd release faster than one mclk cycle
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PMD_RECEIVE_OUTPUT_ENABLE <= `MII_PMD_RX_DISABLED;
    end else if (ROM_ACCESS) begin
      PMD_RECEIVE_OUTPUT_ENABLE <= `MII_PMD_RX_DISABLED;
    end else begin
      PMD_RECEIVE_OUTPUT_ENABLE <= `MII_PMD_RX_ENABLED;
    end
  end

  // rom address bits on the receive pins
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RXD_OUT <= `MII_RESET_NIBBLE;
      RXER_OUT <= `MII_RESET_BIT;
      RXDV_OUT <= `MII_RESET_BIT;
    end else begin
      RXD_OUT <= BOOT_ROM_ADDRESS[`MII_ROM_RXER_BIT-1:`MII_ROM_RXD_LSB];
      RXER_OUT <= BOOT_ROM_ADDRESS[`MII_ROM_RXER_BIT];
      RXDV_OUT <= BOOT_ROM_ADDRESS[`MII_ROM_RXDV_BIT];
    end
  end

  // transmit path: txd/txen change on the pmd clock fall or during rom access, held otherwise
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TXD <= `MII_RESET_NIBBLE;
      TXEN <= 1'b0;
    end else if (ROM_ACCESS) begin
      // address on txd; framing dropped so the pmd never sends it
      TXD <= BOOT_ROM_ADDRESS[`MII_ROM_ADDR_MSB:`MII_ROM_TXD_LSB];
      TXEN <= 1'b0;
    end else if (tx_fall) begin
      if (TX_VALID && EXTERNAL_PHY_SELECT) begin
        TXD <= TX_DATA;
        TXEN <= 1'b1;
      end else begin
        TXEN <= 1'b0;
      end
    end
  end

  // receive path: nibble, valid and error taken at the receive clock rise
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RX_DATA <= `MII_RESET_NIBBLE;
      RX_DATA_VALID <= 1'b0;
      RX_ERROR <= 1'b0;
      RX_STROBE <= 1'b0;
    end else begin
      RX_STROBE <= 1'b0;
      // pins carry rom address during access, so nothing is taken then
      if (rx_rise && EXTERNAL_PHY_SELECT && !ROM_ACCESS) begin
        RX_DATA <= rxd_s;
        RX_DATA_VALID <= rxdv_s;
        RX_ERROR <= rxer_s & rxdv_s;
        RX_STROBE <= 1'b1;
      end
    end
  end

  // carrier and collision status from synchronised copies only
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CARRIER_SENSE <= 1'b0;
      COLLISION <= 1'b0;
    end else begin
      CARRIER_SENSE <= crs_s & EXTERNAL_PHY_SELECT;
      COLLISION <= col_s & EXTERNAL_PHY_SELECT;
    end
  end

  // management clock divider; stopped and low while deselected
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mdc_count <= 8'h00;
      MDC <= 1'b0;
    end else if (!EXTERNAL_PHY_SELECT) begin
      mdc_count <= 8'h00;
      MDC <= 1'b0;
    end else begin
      if (mdc_wrap) begin
        mdc_count <= 8'h00;
      end else begin
        mdc_count <= mdc_count + 8'h01;
      end
      // high for the second half of each period
      MDC <= (mdc_count >= MDC_SAMPLE_AT) && !mdc_wrap;
    end
  end

  // management data: driven from the mdc fall, sampled before the rise
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MDIO_OUT <= 1'b0;
      MDIO_OE <= 1'b0;
      bit_active <= 1'b0;
      MGMT_DONE <= 1'b0;
      MGMT_SAMPLE <= 1'b0;
    end else begin
      MGMT_DONE <= 1'b0;
      if (!EXTERNAL_PHY_SELECT) begin
        MDIO_OE <= 1'b0;
        bit_active <= 1'b0;
      end else if (mdc_wrap) begin
        // without a request the line is released for the pmd's turn
        bit_active <= MGMT_REQ;
        MDIO_OUT <= MGMT_REQ & MGMT_BIT;
        MDIO_OE <= MGMT_REQ & MGMT_DRIVE;
      end else if (mdc_count == MDC_SAMPLE_AT && bit_active) begin
        // two sync cycles late: read data must settle early in the period
        MGMT_SAMPLE <= mdio_s;
        MGMT_DONE <= 1'b1;
        bit_active <= 1'b0;
      end
    end
  end

  // link clocks are taken as free running; a stopped one simply stalls its path
endmodule // mii_port

// file: include/mii_port_defines.vh
// constants for the mii port; its input synchroniser uses none of them
`ifndef MII_PORT_DEFINES_VH
`define MII_PORT_DEFINES_VH

// clock rates in kHz, used to derive the management clock divider
`define MII_MCLK_FREQ_KHZ 20000
`define MII_MDC_MAX_FREQ_KHZ 2500

// synchroniser depth for inputs from outside the MCLK domain
`define MII_SYNC_STAGES 2

// nibble width on the receive and transmit paths
`define MII_NIBBLE_WIDTH 4

// boot rom address bit positions carried by the shared pins
`define MII_ROM_RXD_LSB 6
`define MII_ROM_RXER_BIT 10
`define MII_ROM_RXDV_BIT 11
`define MII_ROM_TXD_LSB 12
`define MII_ROM_ADDR_MSB 15

// receive output enable levels: high lets the pmd drive its receive pins
`define MII_PMD_RX_ENABLED 1'b1
`define MII_PMD_RX_DISABLED 1'b0

// reset values of the pin drivers
`define MII_RESET_NIBBLE 4'h0
`define MII_RESET_BIT 1'b0

`endif

// file: logic/mii_input_sync.v
// two-stage synchroniser bank for asynchronous mii inputs
`timescale 1ns/1ns
module mii_input_sync #(
  parameter WIDTH = 11
) (
  input wire MCLK,
  input wire RESET_N,
  input wire [WIDTH-1:0] ASYNC_IN,
  output wire [WIDTH-1:0] SYNC_OUT
);
  // one flop pair per bit; stage one feeds only stage two
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta; // first stage, may go metastable
      reg stable; // second stage, safe to read
      always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= ASYNC_IN[i];
          stable <= meta;
        end
      end
      assign SYNC_OUT[i] = stable;
    end
  endgenerate
endmodule // mii_input_sync

// file: tb/mii_port_properties.sv
// timing checks on the mii port pins and user side
`timescale 1ns/1ns
module mii_port_checker (
  input wire MCLK,
  input wire RESET_N,
  input wire EXTERNAL_PHY_SELECT,
  input wire ROM_ACCESS,
  input wire [15:6] BOOT_ROM_ADDRESS,
  input wire [3:0] TX_DATA,
  input wire TX_VALID,
  input wire TX_READY,
  input wire CRS,
  input wire CARRIER_SENSE,
  input wire MGMT_READY,
  input wire MGMT_REQ,
  input wire MGMT_DRIVE,
  input wire MGMT_BIT,
  input wire [3:0] RXD_OUT,
  input wire RXER_OUT,
  input wire RXDV_OUT,
  input wire PMD_RECEIVE_OUTPUT_ENABLE,
  input wire [3:0] TXD,
  input wire TXD_OE,
  input wire TXEN,
  input wire MDC,
  input wire MDIO_OUT,
  input wire MDIO_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // one management clock phase is four system clocks
  sequence s_hi4; MDC [*4]; endsequence
  sequence s_lo4; !MDC [*4]; endsequence
  property p_off; !EXTERNAL_PHY_SELECT |=> !TXD_OE && !MDIO_OE; endproperty
  a_off: assert property (p_off)
    else $error("pins driven while deselected");
  property p_rom_quiet; ROM_ACCESS |=> !PMD_RECEIVE_OUTPUT_ENABLE; endproperty
  a_rom_quiet: assert property (p_rom_quiet)
    else $error("pmd left enabled during rom access");
  property p_rom_addr; ROM_ACCESS && EXTERNAL_PHY_SELECT |=>
    !TXEN && {TXD, RXDV_OUT, RXER_OUT, RXD_OUT} == $past(BOOT_ROM_ADDRESS); endproperty
  a_rom_addr: assert property (p_rom_addr)
    else $error("shared pins do not carry the rom address");
  // a stop or restart by deselection is not a period fault
  property p_mdc; disable iff (!RESET_N || !EXTERNAL_PHY_SELECT)
    $rose(MDC) |-> s_hi4 ##1 s_lo4; endproperty
  a_mdc: assert property (p_mdc)
    else $error("management clock period wrong");
  property p_mgmt; MGMT_READY && MGMT_REQ && MGMT_DRIVE |=>
    MDIO_OUT == $past(MGMT_BIT) ##0 MDIO_OE [*8]; endproperty
  a_mgmt: assert property (p_mgmt)
    else $error("management bit not driven for a full period");
  property p_tx; TX_READY |=> TXEN == $past(TX_VALID) && (!TXEN || TXD == $past(TX_DATA));
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit nibble or enable wrong");
  property p_tx_hold; EXTERNAL_PHY_SELECT && !TX_READY && !ROM_ACCESS |=>
    $stable(TXD) && $stable(TXEN); endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit pins moved between clock edges");
  property p_sense; (CRS && EXTERNAL_PHY_SELECT) [*4] |-> CARRIER_SENSE; endproperty
  a_sense: assert property (p_sense)
    else $error("carrier sense not seen after synchronising");
endmodule // mii_port_checker
bind mii_port mii_port_checker chk (.*);

// file: tb/mii_pmd_model.sv
// behavioural external pmd: link clocks, receive nibbles, management turn
`timescale 1ns/1ns
module mii_pmd_model (
  input wire MDC,
  input wire MDIO,
  input wire RX_ENABLE,
  input wire TALK,
  input wire TALK_BIT,
  output reg TXCLK,
  output reg RXCLK,
  output wire [3:0] RXD,
  output wire RXDV,
  output wire RXER,
  output reg MDIO_DRIVE,
  output reg MDIO_VALUE,
  output reg MDIO_SEEN
);
  reg [3:0] rxd = 4'h0;
  reg rxdv = 1'b0;
  reg rxer = 1'b0;
  // disabled pins show the inverse so a stale value never passes
  assign RXD = RX_ENABLE ? rxd : ~rxd;
  assign RXDV = RX_ENABLE ? rxdv : ~rxdv;
  assign RXER = RX_ENABLE ? rxer : ~rxer;
  // both link clocks run free at 2.5 mhz, odd phase to mclk
  initial begin
    TXCLK = 1'b0;
    RXCLK = 1'b0;
    #37;
    forever begin
      #200 TXCLK = ~TXCLK;
      RXCLK = ~RXCLK;
    end
  end
  // nibble launched on the falling edge, stable at the rise
  task rx(input [3:0] d, input dv, input er);
    begin
      @(negedge RXCLK);
      rxd <= d;
      rxdv <= dv;
      rxer <= er & dv;
      @(posedge RXCLK);
    end
  endtask
  // turn on the management line follows the rising clock
  always @(posedge MDC) begin
    MDIO_SEEN <= MDIO;
    MDIO_DRIVE <= TALK;
    MDIO_VALUE <= TALK_BIT;
  end
endmodule // mii_pmd_model

// file: tb/tb.sv
// self-checking bench for the mii port
`timescale 1ns/1ns
// both values copied once, so a queue pop in an argument runs only once
`define CHK(g, e) begin logic [31:0] cg, ce; cg = (g); ce = (e); check_count++; \
  if (cg !== ce) begin failures++; \
  $display("unexpected at %0t got %h expected %h", $time, cg, ce); end end
module tb;
  reg MCLK, RESET_N, EXTERNAL_PHY_SELECT, ROM_ACCESS, TX_VALID, talk, talk_bit;
  reg MGMT_REQ, MGMT_DRIVE, MGMT_BIT, COL, CRS;
  reg [15:6] BOOT_ROM_ADDRESS;
  reg [3:0] TX_DATA;
  reg [31:0] r;
  wire TX_READY, RX_DATA_VALID, RX_ERROR, RX_STROBE, CARRIER_SENSE, COLLISION, TXCLK;
  wire MGMT_READY, MGMT_DONE, MGMT_SAMPLE, RXCLK, RXDV_OUT, RXDV_OE, RXER_OUT, RXER_OE;
  wire PMD_RECEIVE_OUTPUT_ENABLE, PMD_RECEIVE_OUTPUT_ENABLE_OE, TXD_OE, TXEN, TXEN_OE;
  wire MDC, MDC_OE, MDIO_OUT, MDIO_OE, RXD_OE, p_drive, p_value, p_seen, p_dv, p_er;
  wire [3:0] RX_DATA, RXD_OUT, TXD, p_rxd;
  // pin levels from both parties; management line has a pull-up
  wire [3:0] RXD_IN = RXD_OE ? RXD_OUT : p_rxd;
  wire RXDV_IN = RXDV_OE ? RXDV_OUT : p_dv;
  wire RXER_IN = RXER_OE ? RXER_OUT : p_er;
  wire MDIO_IN = MDIO_OE ? MDIO_OUT : (p_drive === 1'b1 ? p_value : 1'b1);
  integer failures = 0, check_count = 0, n;
  reg [5:0] rxq[$];
  reg mq[$];
  reg [3:0] txq[$];
  mii_port DUT (.*);
  mii_pmd_model pmd (.MDC(MDC), .MDIO(MDIO_IN), .RX_ENABLE(PMD_RECEIVE_OUTPUT_ENABLE),
    .TALK(talk), .TALK_BIT(talk_bit), .TXCLK(TXCLK), .RXCLK(RXCLK), .RXD(p_rxd),
    .RXDV(p_dv), .RXER(p_er), .MDIO_DRIVE(p_drive), .MDIO_VALUE(p_value), .MDIO_SEEN(p_seen));
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  task complete_run;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // inputs always change 2 ns after the rising edge
  task step(input integer k);
    begin
      repeat (k) @(posedge MCLK);
      #2;
    end
  endtask
  // bounded wait: 0 transmit ready, 1 management ready, 2 done
  task await(input integer w);
    integer i;
    begin
      for (i = 0; i < 64 && !(w == 0 ? TX_READY === 1'b1 : w == 1 ?
        MGMT_READY === 1'b1 : MGMT_DONE === 1'b1); i++) step(1);
      if (i == 64) begin
        failures++;
        complete_run();
      end
    end
  endtask
  task mbit(input dr, input bt);
    begin
      MGMT_REQ = 1'b1;
      MGMT_DRIVE = dr;
      MGMT_BIT = bt;
      await(1);
      step(1);
      MGMT_REQ = 1'b0;
      await(2);
      step(2);
    end
  endtask
  // result watchers take the oldest note for each result
  always @(posedge MCLK) begin
    if (RX_STROBE === 1'b1 && rxq.size() > 0)
      `CHK({RX_DATA, RX_DATA_VALID, RX_ERROR}, rxq.pop_front())
    if (MGMT_DONE === 1'b1 && mq.size() > 0) `CHK(MGMT_SAMPLE, mq.pop_front())
  end
  always @(posedge TXCLK)
    if (TXEN === 1'b1 && txq.size() > 0) `CHK(TXD, txq.pop_front())
  initial begin
    {RESET_N, ROM_ACCESS, TX_VALID, talk, talk_bit, MGMT_REQ, MGMT_DRIVE, MGMT_BIT} = 8'h00;
    {COL, CRS, TX_DATA, BOOT_ROM_ADDRESS} = 16'h0000;
    EXTERNAL_PHY_SELECT = 1'b1;
    r = $urandom(32'h3631);
    step(3);
    RESET_N = 1'b1;
    step(2);
    TX_VALID = 1'b1;
    for (n = 0; n < 6; n++) begin
      r = $urandom;
      TX_DATA = r[3:0];
      await(0);
      txq.push_back(TX_DATA);
      step(1);
    end
    TX_VALID = 1'b0;
    await(0);
    step(2);
    `CHK(TXEN, 1'b0)
    `CHK(txq.size(), 0)
    $display("transmit test done");
    for (n = 0; n < 8; n++) begin
      r = $urandom;
      pmd.rx(r[3:0], n < 7, n == 3);
      rxq.push_back({r[3:0], n < 7, n == 3});
    end
    step(8);
    `CHK(rxq.size(), 0)
    $display("receive test done");
    ROM_ACCESS = 1'b1;
    for (n = 0; n < 4; n++) begin
      r = $urandom;
      BOOT_ROM_ADDRESS = r[9:0];
      step(1);
      `CHK({TXD, RXDV_OUT, RXER_OUT, RXD_OUT}, BOOT_ROM_ADDRESS)
      `CHK({PMD_RECEIVE_OUTPUT_ENABLE, RXD_IN}, {1'b0, BOOT_ROM_ADDRESS[9:6]})
      `CHK({RXD_OE, RXDV_OE, RXER_OE}, 3'h7)
    end
    ROM_ACCESS = 1'b0;
    step(1);
    `CHK(PMD_RECEIVE_OUTPUT_ENABLE, 1'b1)
    $display("rom test done");
    for (n = 0; n < 4; n++) begin
      r = $urandom;
      mbit(1'b1, r[0]);
      `CHK(p_seen, r[0])
      talk = 1'b1;
      talk_bit = r[1];
      mbit(1'b0, 1'b0);
      mq.push_back(r[1]);
      mbit(1'b0, 1'b0);
      talk = 1'b0;
    end
    `CHK(mq.size(), 0)
    $display("management test done");
    {CRS, COL} = 2'b11;
    step(4);
    `CHK({CARRIER_SENSE, COLLISION}, 2'b11)
    {CRS, COL} = 2'b00;
    step(4);
    `CHK({CARRIER_SENSE, COLLISION}, 2'b00)
    EXTERNAL_PHY_SELECT = 1'b0;
    CRS = 1'b1;
    step(4);
    `CHK({TXD_OE, TXEN_OE, MDC_OE, MDIO_OE, RXD_OE, MDC}, 6'h00)
    `CHK({PMD_RECEIVE_OUTPUT_ENABLE_OE, CARRIER_SENSE}, 2'h0)
    $display("select test done");
    complete_run();
  end
endmodule // tb
